// ---- dv/host_memory_dma_port_bench.sv ----
// self-checking bench: host pin transfers, processor registers and port boot
`timescale 1ns/10ps
module host_memory_dma_port_bench;
   logic clk_sys, rst, port_select_n, address_latch_strobe, port_read_strobe_n;
   logic port_write_strobe_n, port_addr_data_bus_oe, port_acknowledge_n, execution_hold;
   logic boot_mode_a, boot_mode_b, boot_mode_c, cpu_wr_en, cpu_rd_en, short_read_only_mode;
   logic mem_req, mem_we, mem_dm;
   logic [15:0] host_bus, port_addr_data_bus_in, port_addr_data_bus_out, cpu_wdata, cpu_rdata;
   logic [13:0] cpu_addr, mem_addr;
   logic [23:0] mem_wdata, mem_rdata;
   logic [3:0]  program_page_select, data_page_select;
   logic [15:0] r;
   int          err_total = 0;
   int          samples_checked = 0;
   // wire level: device drives when enabled, else the host value
   assign port_addr_data_bus_in = port_addr_data_bus_oe ? port_addr_data_bus_out : host_bus;
   host_memory_dma_port DUT (.clk_sys, .rst, .port_select_n, .address_latch_strobe,
      .port_read_strobe_n, .port_write_strobe_n, .port_addr_data_bus_in,
      .port_addr_data_bus_out, .port_addr_data_bus_oe, .port_acknowledge_n, .boot_mode_a,
      .boot_mode_b, .boot_mode_c, .execution_hold, .cpu_wr_en, .cpu_rd_en, .cpu_addr,
      .cpu_wdata, .cpu_rdata, .mem_req, .mem_we, .mem_dm, .mem_addr, .mem_wdata, .mem_rdata,
      .program_page_select, .data_page_select, .short_read_only_mode);
   onchip_memory_model mem (.clk_sys, .mem_req, .mem_we, .mem_dm, .mem_addr, .mem_wdata,
      .mem_rdata);
   initial begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // host looks at acknowledge before every transfer
   task automatic ready();
      for (int i = 0; i < 20 && port_acknowledge_n !== 1'b0; i++) tick(1);
   endtask
   task automatic latch(input logic [15:0] w);
      ready();
      address_latch_strobe = 1;
      host_bus = w;
      tick(1);
      port_select_n = 0;
      tick(2);
      port_select_n = 1;
      address_latch_strobe = 0;
      host_bus = ~w;
      tick(2);
   endtask
   task automatic access(input logic wr, input logic [15:0] w, output logic [15:0] rd);
      ready();
      port_select_n = 0;
      host_bus = w;
      if (wr) port_write_strobe_n = 0;
      else port_read_strobe_n = 0;
      // poll just after each edge so the outputs have settled
      for (int i = 0; i < 8 && port_acknowledge_n !== 1'b1; i++) tick(1);
      for (int i = 0; i < 8 && port_acknowledge_n !== 1'b0; i++) tick(1);
      check(port_acknowledge_n, 1'b0);
      if (!wr) check(port_addr_data_bus_oe, 1'b1);
      rd = port_addr_data_bus_out;
      port_select_n = 1;
      port_read_strobe_n = 1;
      port_write_strobe_n = 1;
      host_bus = ~w;
      tick(3);
   endtask
   task automatic cpu_wr(input logic [13:0] a, input logic [15:0] d);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr_en = 1;
      tick(1);
      cpu_wr_en = 0;
      tick(1);
   endtask
   task automatic cpu_rd(input logic [13:0] a, output logic [15:0] d);
      cpu_addr = a;
      cpu_rd_en = 1;
      tick(1);
      cpu_rd_en = 0;
      d = cpu_rdata;
   endtask
   task automatic t_reset();
      check(port_acknowledge_n, 1'b0);
      check(port_addr_data_bus_oe, 1'b0);
      check(execution_hold, 1'b1);
      check({program_page_select, data_page_select, short_read_only_mode}, 9'h000);
   endtask
   task automatic t_dm_burst();
      latch(16'h4100);
      access(1, 16'h1111, r);
      access(1, 16'h2222, r);
      check(mem.dm[14'h0100], 16'h1111);
      check(mem.dm[14'h0101], 16'h2222);
      check(execution_hold, 1'b1);
      latch(16'h4100);
      access(0, 16'h0000, r);
      check(r, 16'h1111);
      access(0, 16'h0000, r);
      check(r, 16'h2222);
   endtask
   task automatic t_pm_boot();
      latch(16'h0000);
      access(1, 16'hABCD, r);
      check(execution_hold, 1'b1);
      access(1, 16'h0012, r);
      check(mem.pm[14'h0000], 24'hABCD12);
      check(execution_hold, 1'b0);
      latch(16'h0000);
      access(0, 16'h0000, r);
      check(r, 16'hABCD);
      access(0, 16'h0000, r);
      check(r, 16'h0012);
   endtask
   task automatic t_overlay_guard();
      latch(16'h8035);
      check({data_page_select, program_page_select}, 8'h35);
      cpu_rd(14'h3FE0, r);
      check(r, 16'h0035);
      latch(16'h7FE0);
      access(1, 16'h1234, r);
      check(mem.guard_hits, 0);
   endtask
   task automatic t_cpu_regs();
      cpu_wr(14'h3FE7, 16'h4000);
      check(short_read_only_mode, 1'b1);
      cpu_rd(14'h3FE7, r);
      check(r, 16'h4000);
      cpu_wr(14'h3FE1, 16'h4101);
      access(0, 16'h0000, r);
      check(r, 16'h2222);
      cpu_rd(14'h3FE1, r);
      check(r, 16'h0000);
      cpu_wr(14'h3FE0, 16'h00A6);
      check({data_page_select, program_page_select}, 8'hA6);
   endtask
   task automatic stop_test();
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // roughly forty times the expected run of about 115 cycles
   initial begin
      #200000;
      err_total++;
      stop_test();
   end
   initial begin
      {rst, port_select_n, port_read_strobe_n, port_write_strobe_n} = 4'hF;
      {address_latch_strobe, cpu_wr_en, cpu_rd_en} = 3'h0;
      {boot_mode_c, boot_mode_b, boot_mode_a} = 3'h5;
      host_bus = 16'h0000;
      cpu_addr = 14'h0000;
      cpu_wdata = 16'h0000;
      tick(4);
      rst = 0;
      tick(1);
      t_reset();
      t_dm_burst();
      t_pm_boot();
      t_overlay_guard();
      t_cpu_regs();
      stop_test();
   end
endmodule

// ---- dv/host_port_monitor.sv ----
// concurrent checks on the host memory port top-level pins
`timescale 1ns/10ps
module host_port_monitor (
   input wire logic                             clk_sys,
   input wire logic                             rst,
   input wire logic                             port_acknowledge_n,
   input wire logic                             port_addr_data_bus_oe,
   input wire logic                             execution_hold,
   input wire logic                             boot_mode_a,
   input wire logic                             boot_mode_b,
   input wire logic                             boot_mode_c,
   input wire logic                             cpu_wr_en,
   input wire logic                             cpu_rd_en,
   input wire logic [host_port_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [host_port_pkg::BUS_W-1:0]  cpu_wdata,
   input wire logic [host_port_pkg::BUS_W-1:0]  cpu_rdata,
   input wire logic                             mem_req,
   input wire logic                             mem_we,
   input wire logic                             mem_dm,
   input wire logic [host_port_pkg::ADDR_W-1:0] mem_addr,
   input wire logic                             short_read_only_mode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_busy_on_req: assert property (mem_req |-> port_acknowledge_n)
      else $error("memory access while acknowledge shows ready");
   chk_ack_after_req: assert property (mem_req |-> ##2 !port_acknowledge_n)
      else $error("acknowledge not back two cycles after access");
   chk_one_mem_cycle: assert property (mem_req |=> !mem_req)
      else $error("memory request longer than one cycle");
   // past reset guards keep a short mid-run reset from looking like an edge
   chk_busy_two_cycles: assert property ($rose(port_acknowledge_n) && !$past(rst)
      |-> ##1 port_acknowledge_n ##1 !port_acknowledge_n)
      else $error("busy window not two cycles");
   chk_drive_when_done: assert property (port_addr_data_bus_oe |-> !port_acknowledge_n)
      else $error("bus driven while busy");
   chk_guard_ctrl_regs: assert property (mem_req && mem_we && mem_dm
      |-> mem_addr < host_port_pkg::CTRL_REGION_BASE)
      else $error("memory write into control register region");
   chk_boot_hold_rise: assert property ($rose(execution_hold)
      |-> $past(rst, 2) && boot_mode_c && !boot_mode_b && boot_mode_a)
      else $error("hold raised without port boot straps");
   chk_boot_hold_drop: assert property ($fell(execution_hold) && !$past(rst)
      |-> $past(mem_req) && $past(mem_we) && !$past(mem_dm) && $past(mem_addr) == 14'h0000)
      else $error("hold dropped without program location zero write");
   chk_short_read_bit: assert property (cpu_wr_en && cpu_addr == 14'h3FE7
      |=> short_read_only_mode == $past(cpu_wdata[14]))
      else $error("short read mode does not follow config bit");
   chk_addr_unreadable: assert property (cpu_rd_en && cpu_addr == 14'h3FE1
      |=> cpu_rdata == 16'h0000)
      else $error("start address readable");
endmodule
bind host_memory_dma_port host_port_monitor u_mon (.clk_sys, .rst, .port_acknowledge_n,
   .port_addr_data_bus_oe, .execution_hold, .boot_mode_a, .boot_mode_b, .boot_mode_c,
   .cpu_wr_en, .cpu_rd_en, .cpu_addr, .cpu_wdata, .cpu_rdata, .mem_req, .mem_we, .mem_dm,
   .mem_addr, .short_read_only_mode);

// ---- dv/onchip_memory_model.sv ----
// on-chip program and data memory answering the port's stolen cycles
`timescale 1ns/10ps
module onchip_memory_model (
   input wire logic        clk_sys,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic        mem_dm,
   input wire logic [13:0] mem_addr,
   input wire logic [23:0] mem_wdata,
   output logic [23:0]     mem_rdata
);
   logic [15:0] dm [0:16383];
   logic [23:0] pm [0:16383];
   int          guard_hits = 0;
   initial mem_rdata = 24'h000000;
   // read data stands for one cycle only, then turns over so stale data cannot match
   always @(posedge clk_sys) begin
      if (mem_req && mem_we && mem_dm && mem_addr >= 14'h3FE0)
         guard_hits <= guard_hits + 1;
      else if (mem_req && mem_we && mem_dm)
         dm[mem_addr] <= mem_wdata[15:0];
      else if (mem_req && mem_we)
         pm[mem_addr] <= mem_wdata;
      if (mem_req && !mem_we)
         mem_rdata <= mem_dm ? {8'h00, dm[mem_addr]} : pm[mem_addr];
      else
         mem_rdata <= ~mem_rdata;
   end
endmodule

// ---- logic/host_boot_hold.sv ----
// catches the boot mode pins after reset and holds execution for port boot
`timescale 1ns/10ps
module host_boot_hold (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // boot straps
   input  wire logic       boot_mode_a,
   input  wire logic       boot_mode_b,
   input  wire logic       boot_mode_c,
   // release event from the port
   input  wire logic       pm_zero_written,
   // hold to the sequencer
   output logic            execution_hold
);
   typedef struct packed {
      logic captured;
      logic hold;
   } boot_t;

   boot_t cur;
   boot_t next_cur;

   always_comb begin
      next_cur = cur;
      // straps are caught by the first clock after release, not by the reset itself
      if (!cur.captured) begin
         next_cur.captured = 1'b1;
         next_cur.hold = ({boot_mode_c, boot_mode_b, boot_mode_a} ==
                          host_port_pkg::BOOT_MODE_HOST_PORT);
      end else if (pm_zero_written) begin
         next_cur.hold = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cur <= '{captured: 1'b0, hold: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   assign execution_hold = cur.hold;
endmodule

// ---- logic/host_memory_dma_port.sv ----
// host memory port: multiplexed host bus to on-chip program and data memory
`timescale 1ns/10ps
module host_memory_dma_port (
   // clock and reset
   input  wire logic                              clk_sys,
   input  wire logic                              rst,
   // host pins
   input  wire logic                              port_select_n,
   input  wire logic                              address_latch_strobe,
   input  wire logic                              port_read_strobe_n,
   input  wire logic                              port_write_strobe_n,
   input  wire logic [host_port_pkg::BUS_W-1:0]   port_addr_data_bus_in,
   output logic [host_port_pkg::BUS_W-1:0]        port_addr_data_bus_out,
   output logic                                   port_addr_data_bus_oe,
   output logic                                   port_acknowledge_n,
   // boot straps and execution hold
   input  wire logic                              boot_mode_a,
   input  wire logic                              boot_mode_b,
   input  wire logic                              boot_mode_c,
   output logic                                   execution_hold,
   // processor data-memory-mapped register access
   input  wire logic                              cpu_wr_en,
   input  wire logic                              cpu_rd_en,
   input  wire logic [host_port_pkg::ADDR_W-1:0]  cpu_addr,
   input  wire logic [host_port_pkg::BUS_W-1:0]   cpu_wdata,
   output logic [host_port_pkg::BUS_W-1:0]        cpu_rdata,
   // on-chip memory, at most one stolen cycle per access, read data one cycle after request
   output logic                                   mem_req,
   output logic                                   mem_we,
   output logic                                   mem_dm,
   output logic [host_port_pkg::ADDR_W-1:0]       mem_addr,
   output logic [host_port_pkg::PM_W-1:0]         mem_wdata,
   input  wire logic [host_port_pkg::PM_W-1:0]    mem_rdata,
   // overlay selections and timing mode
   output logic [host_port_pkg::PAGE_FIELD_W-1:0] program_page_select,
   output logic [host_port_pkg::PAGE_FIELD_W-1:0] data_page_select,
   output logic                                   short_read_only_mode
);
   typedef struct packed {
      host_port_pkg::port_state_t          state;
      logic [host_port_pkg::ADDR_W-1:0]    addr;
      logic                                target_dm;
      logic                                second_half;
      logic                                is_read;
      logic [host_port_pkg::BUS_W-1:0]     hold_word;
      logic [host_port_pkg::PAGE_W-1:0]    overlay_page;
      logic                                short_read_mode;
      logic                                ack_n;
      logic [host_port_pkg::BUS_W-1:0]     bus_out;
      logic                                bus_oe;
      logic                                mem_req;
      logic                                mem_we;
      logic                                mem_dm;
      logic [host_port_pkg::ADDR_W-1:0]    mem_addr;
      logic [host_port_pkg::PM_W-1:0]      mem_wdata;
      logic [host_port_pkg::BUS_W-1:0]     cpu_rdata;
      logic                                pm_zero_written;
   } port_t;

   port_t cur;
   port_t next_cur;

   logic                             s_sel_n;
   logic                             s_ale;
   logic                             s_rd_n;
   logic                             s_wr_n;
   logic [host_port_pkg::BUS_W-1:0]  s_bus;
   logic                             s_sel_fall;
   logic                             access_start;
   logic                             write_req;

   host_strobe_sampler u_sampler (
      .clk_sys              (clk_sys),
      .rst                  (rst),
      .port_select_n        (port_select_n),
      .address_latch_strobe (address_latch_strobe),
      .port_read_strobe_n   (port_read_strobe_n),
      .port_write_strobe_n  (port_write_strobe_n),
      .bus_in               (port_addr_data_bus_in),
      .sel_n                (s_sel_n),
      .ale                  (s_ale),
      .rd_n                 (s_rd_n),
      .wr_n                 (s_wr_n),
      .bus                  (s_bus),
      .sel_fall             (s_sel_fall)
   );

   host_boot_hold u_boot (
      .clk_sys         (clk_sys),
      .rst             (rst),
      .boot_mode_a     (boot_mode_a),
      .boot_mode_b     (boot_mode_b),
      .boot_mode_c     (boot_mode_c),
      .pm_zero_written (cur.pm_zero_written),
      .execution_hold  (execution_hold)
   );

   // control registers live at the top of data memory and host writes to them are blocked
   function automatic logic in_ctrl_region(input logic dm,
                                           input logic [host_port_pkg::ADDR_W-1:0] a);
      in_ctrl_region = dm && (a >= host_port_pkg::CTRL_REGION_BASE);
   endfunction

   function automatic logic [host_port_pkg::BUS_W-1:0] overlay_word(
      input logic [host_port_pkg::PAGE_W-1:0] page);
      overlay_word = {{(host_port_pkg::BUS_W-host_port_pkg::PAGE_W){1'b0}}, page};
   endfunction

   assign access_start = ~s_sel_n & ~s_ale & (~s_rd_n | ~s_wr_n);
   assign write_req    = s_rd_n & ~s_wr_n;

   always_comb begin
      next_cur                 = cur;
      next_cur.mem_req         = 1'b0;
      next_cur.mem_we          = 1'b0;
      next_cur.pm_zero_written = 1'b0;

      // processor side register writes
      if (cpu_wr_en) begin
         if (cpu_addr == host_port_pkg::OVERLAY_PAGE_OFFSET) begin
            next_cur.overlay_page = cpu_wdata[host_port_pkg::PAGE_W-1:0];
         end
         if (cpu_addr == host_port_pkg::START_ADDR_OFFSET) begin
            next_cur.addr        = cpu_wdata[host_port_pkg::ADDR_W-1:0];
            next_cur.target_dm   = cpu_wdata[host_port_pkg::CW_TARGET_BIT];
            next_cur.second_half = 1'b0;
         end
         if (cpu_addr == host_port_pkg::MEM_CONFIG_OFFSET) begin
            next_cur.short_read_mode = cpu_wdata[host_port_pkg::SHORT_READ_MODE_BIT];
         end
      end

      // the start address register is write only, so it reads as zero
      if (cpu_rd_en) begin
         if (cpu_addr == host_port_pkg::OVERLAY_PAGE_OFFSET) begin
            next_cur.cpu_rdata = overlay_word(cur.overlay_page);
         end else if (cpu_addr == host_port_pkg::MEM_CONFIG_OFFSET) begin
            next_cur.cpu_rdata = host_port_pkg::WORD_ZERO;
            next_cur.cpu_rdata[host_port_pkg::SHORT_READ_MODE_BIT] = cur.short_read_mode;
         end else begin
            next_cur.cpu_rdata = host_port_pkg::WORD_ZERO;
         end
      end

      case (cur.state)
         host_port_pkg::ST_IDLE: begin
            next_cur.ack_n  = 1'b0;
            next_cur.bus_oe = 1'b0;
            // a host control word overrides a processor write in the same cycle
            if (s_sel_fall && s_ale) begin
               if (s_bus[host_port_pkg::CW_PAGE_FLAG_BIT]) begin
                  next_cur.overlay_page = s_bus[host_port_pkg::PAGE_W-1:0];
               end else begin
                  next_cur.addr        = s_bus[host_port_pkg::ADDR_W-1:0];
                  next_cur.target_dm   = s_bus[host_port_pkg::CW_TARGET_BIT];
                  next_cur.second_half = 1'b0;
               end
            end else if (access_start) begin
               next_cur.state    = host_port_pkg::ST_ACCESS;
               next_cur.ack_n    = 1'b1;
               next_cur.is_read  = ~write_req;
               next_cur.mem_addr = cur.addr;
               next_cur.mem_dm   = cur.target_dm;
               if (cur.target_dm) begin
                  next_cur.mem_req   = 1'b1;
                  next_cur.mem_we    = write_req && !in_ctrl_region(cur.target_dm, cur.addr);
                  next_cur.mem_wdata = {host_port_pkg::BYTE_ZERO, s_bus};
               end else if (!cur.second_half) begin
                  // first part: read fetches the whole word, write only holds the upper 16
                  next_cur.mem_req = ~write_req;
                  if (write_req) begin
                     next_cur.hold_word = s_bus;
                  end
               end else if (write_req) begin
                  next_cur.mem_req   = 1'b1;
                  next_cur.mem_we    = 1'b1;
                  next_cur.mem_wdata = {cur.hold_word, s_bus[host_port_pkg::PM_LOW_W-1:0]};
                  next_cur.pm_zero_written = (cur.addr == host_port_pkg::ADDR_ZERO);
               end
            end
         end
         host_port_pkg::ST_ACCESS: begin
            next_cur.state = host_port_pkg::ST_FETCH;
         end
         host_port_pkg::ST_FETCH: begin
            if (cur.is_read) begin
               if (cur.target_dm) begin
                  next_cur.bus_out = mem_rdata[host_port_pkg::BUS_W-1:0];
               end else if (!cur.second_half) begin
                  next_cur.bus_out   = mem_rdata[host_port_pkg::PM_W-1:host_port_pkg::PM_LOW_W];
                  next_cur.hold_word = {host_port_pkg::BYTE_ZERO,
                                        mem_rdata[host_port_pkg::PM_LOW_W-1:0]};
               end else begin
                  next_cur.bus_out = {host_port_pkg::BYTE_ZERO,
                                      cur.hold_word[host_port_pkg::PM_LOW_W-1:0]};
               end
            end
            if (cur.target_dm || cur.second_half) begin
               next_cur.addr        = cur.addr + host_port_pkg::ADDR_STEP;
               next_cur.second_half = 1'b0;
            end else begin
               next_cur.second_half = 1'b1;
            end
            next_cur.ack_n  = 1'b0;
            next_cur.bus_oe = cur.is_read;
            next_cur.state  = host_port_pkg::ST_RELEASE;
         end
         host_port_pkg::ST_RELEASE: begin
            // the bus is driven only while the host still holds its read strobe
            if (s_sel_n || (s_rd_n && s_wr_n)) begin
               next_cur.bus_oe = 1'b0;
               next_cur.state  = host_port_pkg::ST_IDLE;
            end
         end
         default: begin
            next_cur.state  = host_port_pkg::ST_IDLE;
            next_cur.bus_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cur <= '{state:           host_port_pkg::ST_IDLE,
                  addr:            host_port_pkg::ADDR_ZERO,
                  target_dm:       1'b0,
                  second_half:     1'b0,
                  is_read:         1'b0,
                  hold_word:       host_port_pkg::WORD_ZERO,
                  overlay_page:    host_port_pkg::PAGE_RESET,
                  short_read_mode: 1'b0,
                  ack_n:           1'b1,
                  bus_out:         host_port_pkg::WORD_ZERO,
                  bus_oe:          1'b0,
                  mem_req:         1'b0,
                  mem_we:          1'b0,
                  mem_dm:          1'b0,
                  mem_addr:        host_port_pkg::ADDR_ZERO,
                  mem_wdata:       host_port_pkg::PM_WORD_ZERO,
                  cpu_rdata:       host_port_pkg::WORD_ZERO,
                  pm_zero_written: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   // the latched address has no read path to the host bus
   assign port_addr_data_bus_out = cur.bus_out;
   assign port_addr_data_bus_oe  = cur.bus_oe;
   assign port_acknowledge_n     = cur.ack_n;
   assign cpu_rdata              = cur.cpu_rdata;
   assign mem_req                = cur.mem_req;
   assign mem_we                 = cur.mem_we;
   assign mem_dm                 = cur.mem_dm;
   assign mem_addr               = cur.mem_addr;
   assign mem_wdata              = cur.mem_wdata;
   assign short_read_only_mode   = cur.short_read_mode;
   assign program_page_select    =
      cur.overlay_page[host_port_pkg::PM_PAGE_LSB +: host_port_pkg::PAGE_FIELD_W];
   assign data_page_select       =
      cur.overlay_page[host_port_pkg::DM_PAGE_LSB +: host_port_pkg::PAGE_FIELD_W];
endmodule

// ---- logic/host_strobe_sampler.sv ----
// registers the host pins once per clock and flags the select falling edge
`timescale 1ns/10ps
module host_strobe_sampler (
   // clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           rst,
   // raw host pins
   input  wire logic                           port_select_n,
   input  wire logic                           address_latch_strobe,
   input  wire logic                           port_read_strobe_n,
   input  wire logic                           port_write_strobe_n,
   input  wire logic [host_port_pkg::BUS_W-1:0] bus_in,
   // sampled view
   output logic                                sel_n,
   output logic                                ale,
   output logic                                rd_n,
   output logic                                wr_n,
   output logic [host_port_pkg::BUS_W-1:0]     bus,
   output logic                                sel_fall
);
   typedef struct packed {
      logic                           sel_n;
      logic                           sel_n_prev;
      logic                           ale;
      logic                           rd_n;
      logic                           wr_n;
      logic [host_port_pkg::BUS_W-1:0] bus;
   } sample_t;

   sample_t cur;
   sample_t next_cur;

   // this register stage is the single synchronising cycle ahead of an access
   always_comb begin
      next_cur            = cur;
      next_cur.sel_n      = port_select_n;
      next_cur.sel_n_prev = cur.sel_n;
      next_cur.ale        = address_latch_strobe;
      next_cur.rd_n       = port_read_strobe_n;
      next_cur.wr_n       = port_write_strobe_n;
      next_cur.bus        = bus_in;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cur <= '{sel_n: 1'b1, sel_n_prev: 1'b1, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
                  bus: host_port_pkg::WORD_ZERO};
      end else begin
         cur <= next_cur;
      end
   end

   assign sel_n    = cur.sel_n;
   assign ale      = cur.ale;
   assign rd_n     = cur.rd_n;
   assign wr_n     = cur.wr_n;
   assign bus      = cur.bus;
   assign sel_fall = cur.sel_n_prev & ~cur.sel_n;
endmodule

// ---- shared/host_port_pkg.sv ----
// constants and types for the host memory port
package host_port_pkg;
   localparam int BUS_W       = 16;
   localparam int ADDR_W      = 14;
   localparam int PM_W        = 24;
   localparam int PAGE_W      = 8;
   localparam int PAGE_FIELD_W = 4;
   localparam int PM_LOW_W    = 8;

   // processor data-memory addresses of the port registers
   localparam logic [ADDR_W-1:0] OVERLAY_PAGE_OFFSET = 14'h3FE0;
   localparam logic [ADDR_W-1:0] START_ADDR_OFFSET   = 14'h3FE1;
   localparam logic [ADDR_W-1:0] MEM_CONFIG_OFFSET   = 14'h3FE7;
   localparam logic [ADDR_W-1:0] CTRL_REGION_BASE    = 14'h3FE0;

   // control word and register fields
   localparam int CW_PAGE_FLAG_BIT    = 15;
   localparam int CW_TARGET_BIT       = 14;
   localparam int SHORT_READ_MODE_BIT = 14;
   localparam int PM_PAGE_LSB         = 0;
   localparam int DM_PAGE_LSB         = 4;

   localparam logic [ADDR_W-1:0] ADDR_STEP      = 14'h0001;
   localparam logic [ADDR_W-1:0] ADDR_ZERO      = 14'h0000;
   localparam logic [PAGE_W-1:0] PAGE_RESET     = 8'h00;
   localparam logic [BUS_W-1:0]  WORD_ZERO      = 16'h0000;
   localparam logic [PM_LOW_W-1:0] BYTE_ZERO    = 8'h00;
   localparam logic [PM_W-1:0]   PM_WORD_ZERO   = 24'h000000;

   // boot mode pins in order C, B, A
   localparam logic [2:0] BOOT_MODE_HOST_PORT = 3'h5;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ACCESS  = 2'b01,
      ST_FETCH   = 2'b10,
      ST_RELEASE = 2'b11
   } port_state_t;
endpackage
